// ### inc/pmr_pkg.sv
// constants and types shared by the shutdown-source and rail-voltage register group
`default_nettype none
package pmr_pkg;
    // register offsets on the serial target port
    localparam logic [7:0] PMR_OFS_IRQ   = 8'h02;
    localparam logic [7:0] PMR_OFS_MASK  = 8'h03;
    localparam logic [7:0] PMR_OFS_FLAGS = 8'h05;
    localparam logic [7:0] PMR_OFS_RAIL1 = 8'h20;
    localparam logic [7:0] PMR_OFS_RAIL2 = 8'h21;
    localparam logic [7:0] PMR_OFS_RAIL3 = 8'h23;

    // field widths
    localparam int PMR_FLAG_W = 4;
    localparam int PMR_VID_W  = 7;

    // bit positions in the cause flags and the interrupt pair
    localparam int PMR_BIT_ENPIN = 3;
    localparam int PMR_BIT_UV    = 2;
    localparam int PMR_BIT_PF    = 1;
    localparam int PMR_BIT_CT    = 0;
    localparam int PMR_BIT_SDEV  = 3;

    // values after reset
    localparam logic [7:0] PMR_RST_RAIL1 = 8'h38;
    localparam logic [7:0] PMR_RST_RAIL2 = 8'h00;
    localparam logic [7:0] PMR_RST_RAIL3 = 8'h11;
    localparam logic [3:0] PMR_RST_FLAGS = 4'h0;
    localparam logic       PMR_RST_IRQ   = 1'b0;
    localparam logic       PMR_RST_MASK  = 1'b1;

    // reserved bits as they read back
    localparam logic [7:0] PMR_RSVD_IRQ  = 8'h00;
    localparam logic [7:0] PMR_RSVD_MASK = 8'hf7;
    localparam logic [7:0] PMR_RD_UNMAP  = 8'h00;

    // serial target: 7-bit address (value arbitrary), bits in a byte
    localparam logic [6:0] PMR_I2C_ADDR  = 7'h2a;
    localparam logic [3:0] PMR_BYTE_BITS = 4'h8;

    typedef enum logic [3:0] {
        PMR_ST_IDLE, PMR_ST_ADDR, PMR_ST_AACK, PMR_ST_PTR, PMR_ST_PACK,
        PMR_ST_WDATA, PMR_ST_WACK, PMR_ST_RDATA, PMR_ST_RDACK
    } pmr_i2c_state_t;
endpackage : pmr_pkg
`default_nettype wire

// ### inc/pmr_regbus_if.sv
// internal register access path between the serial target and the register bank
`default_nettype none
interface pmr_regbus_if;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport target (output wr, output addr, output wdata, input rdata);
    modport bank   (input wr, input addr, input wdata, output rdata);
endinterface : pmr_regbus_if
`default_nettype wire

// ### design/pmr_i2c_target.sv
// serial two-wire target: address match, register pointer, auto-increment reads and writes
`default_nettype none
module pmr_i2c_target (
    input  wire logic      clk,
    input  wire logic      rst,
    input  wire logic      scl_pin,
    input  wire logic      sda_in,
    output logic           sda_oe,
    pmr_regbus_if.target   bus
);
    import pmr_pkg::*;

    logic [1:0]     scl_s, next_scl_s, sda_s, next_sda_s;
    logic           scl_q, next_scl_q, sda_q, next_sda_q;
    logic           scl_r, scl_f, start, stop;
    pmr_i2c_state_t state, next_state;
    logic [3:0]     cnt, next_cnt;
    logic [7:0]     shreg, next_shreg, ptr, next_ptr;
    logic           rd, next_rd, oe, next_oe, wr, next_wr;

    // two-flop synchronisers; the second stage and a flop holding its previous value feed edge detection
    always_comb begin
        next_scl_s = {scl_s[0], scl_pin};
        next_sda_s = {sda_s[0], sda_in};
        next_scl_q = scl_s[1];
        next_sda_q = sda_s[1];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            scl_s <= 2'h3;
            sda_s <= 2'h3;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_s <= next_scl_s;
            sda_s <= next_sda_s;
            scl_q <= next_scl_q;
            sda_q <= next_sda_q;
        end
    end

    assign scl_r = scl_s[1] & ~scl_q;
    assign scl_f = ~scl_s[1] & scl_q;
    assign start = scl_s[1] & scl_q & sda_q & ~sda_s[1];
    assign stop  = scl_s[1] & scl_q & ~sda_q & sda_s[1];

    // protocol sequencer; data changes only on scl falling edges
    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        next_shreg = shreg;
        next_ptr   = ptr;
        next_rd    = rd;
        next_oe    = oe;
        next_wr    = 1'b0;
        if (start) begin
            next_state = PMR_ST_ADDR;
            next_cnt   = 4'h0;
            next_oe    = 1'b0;
        end else if (stop) begin
            next_state = PMR_ST_IDLE;
            next_oe    = 1'b0;
        end else if (scl_r) begin
            case (state)
                PMR_ST_ADDR, PMR_ST_PTR, PMR_ST_WDATA: begin
                    if (cnt < PMR_BYTE_BITS) begin
                        next_shreg = {shreg[6:0], sda_s[1]};
                        next_cnt   = cnt + 4'h1;
                    end
                end
                PMR_ST_RDACK: begin
                    if (sda_s[1]) begin
                        next_state = PMR_ST_IDLE; // controller ended the read
                    end
                end
                default: begin
                end
            endcase
        end else if (scl_f) begin
            case (state)
                PMR_ST_ADDR: begin
                    if (cnt == PMR_BYTE_BITS) begin
                        if (shreg[7:1] == PMR_I2C_ADDR) begin
                            next_oe    = 1'b1;
                            next_rd    = shreg[0];
                            next_state = PMR_ST_AACK;
                        end else begin
                            next_state = PMR_ST_IDLE;
                        end
                    end
                end
                PMR_ST_AACK, PMR_ST_RDACK: begin
                    if (state == PMR_ST_RDACK || rd) begin
                        next_shreg = bus.rdata;
                        next_oe    = ~bus.rdata[7];
                        next_cnt   = 4'h1;
                        next_state = PMR_ST_RDATA;
                    end else begin
                        next_oe    = 1'b0;
                        next_cnt   = 4'h0;
                        next_state = PMR_ST_PTR;
                    end
                end
                PMR_ST_PTR: begin
                    if (cnt == PMR_BYTE_BITS) begin
                        next_ptr   = shreg;
                        next_oe    = 1'b1;
                        next_state = PMR_ST_PACK;
                    end
                end
                PMR_ST_WDATA: begin
                    if (cnt == PMR_BYTE_BITS) begin
                        next_wr    = 1'b1;
                        next_oe    = 1'b1;
                        next_state = PMR_ST_WACK;
                    end
                end
                PMR_ST_PACK, PMR_ST_WACK: begin
                    if (state == PMR_ST_WACK) begin
                        next_ptr = ptr + 8'h01;
                    end
                    next_oe    = 1'b0;
                    next_cnt   = 4'h0;
                    next_state = PMR_ST_WDATA;
                end
                PMR_ST_RDATA: begin
                    if (cnt == PMR_BYTE_BITS) begin
                        next_oe    = 1'b0;
                        next_ptr   = ptr + 8'h01;
                        next_state = PMR_ST_RDACK;
                    end else begin
                        next_shreg = {shreg[6:0], 1'b0};
                        next_oe    = ~shreg[6];
                        next_cnt   = cnt + 4'h1;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= PMR_ST_IDLE;
            cnt   <= 4'h0;
            shreg <= 8'h00;
            ptr   <= 8'h00;
            rd    <= 1'b0;
            oe    <= 1'b0;
            wr    <= 1'b0;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
            shreg <= next_shreg;
            ptr   <= next_ptr;
            rd    <= next_rd;
            oe    <= next_oe;
            wr    <= next_wr;
        end
    end

    assign sda_oe    = oe;
    assign bus.wr    = wr;
    assign bus.addr  = ptr;
    assign bus.wdata = shreg;
endmodule : pmr_i2c_target
`default_nettype wire

// ### design/pmr_shutdown_rail_regs.sv
// shutdown-cause flags, shutdown interrupt bit and mask, and three rail voltage codes
// Functional notes
// - cause flags are set by the device and cleared only by writing one
// - enable pin deassertion sets the enable-pin shutdown flag, bit 3
// - undervoltage lockout shutdown sets flag bit 2
// - power fault shutdown sets flag bit 1
// - critical temperature shutdown sets flag bit 0
// - undervoltage, power fault or critical temperature also set the shutdown interrupt bit
// - rail 1 code in bits 6 to 0, resets to 0111000
// - rail 2 code at offset 21h resets to zero
// - rail 3 code resets to 0010001
// - code zero is valid; power goods stay high at code zero or sleep low
// - shutdown interrupt is bit 3 at 02h, cleared by writing one
// - its mask is bit 3 at 03h, resets to one, zero unmasks
`default_nettype none
module pmr_shutdown_rail_regs (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  scl_pin,
    input  wire logic                  sda_in,
    output logic                       sda_out,
    output logic                       sda_oe,
    input  wire logic                  device_enable_pin,
    input  wire logic                  sleep_s0_signal,
    input  wire logic                  undervoltage_trip,
    input  wire logic                  power_fault_trip,
    input  wire logic                  critical_temp_trip,
    input  wire logic [2:0]            rail_pg_raw,
    output logic [pmr_pkg::PMR_VID_W-1:0] rail1_voltage_field,
    output logic [pmr_pkg::PMR_VID_W-1:0] rail2_voltage_field,
    output logic [pmr_pkg::PMR_VID_W-1:0] rail3_voltage_field,
    output logic [2:0]                 power_good,
    output logic                       shutdown_irq_pending
);
    import pmr_pkg::*;

    pmr_regbus_if bus ();

    pmr_i2c_target u_target (
        .clk     (clk),
        .rst     (rst),
        .scl_pin (scl_pin),
        .sda_in  (sda_in),
        .sda_oe  (sda_oe),
        .bus     (bus.target)
    );

    // open-drain: only ever pull low
    assign sda_out = 1'b0;

    logic [1:0] pin_s1, next_pin_s1, pin_s2, next_pin_s2;
    logic       en_last, next_en_last;
    logic       en_fall, sleep_low;

    // pins cross in through two flops; bit 1 sleep, bit 0 enable
    always_comb begin
        next_pin_s1  = {sleep_s0_signal, device_enable_pin};
        next_pin_s2  = pin_s1;
        next_en_last = pin_s2[0];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pin_s1  <= 2'h0;
            pin_s2  <= 2'h0;
            en_last <= 1'b0;
        end else begin
            pin_s1  <= next_pin_s1;
            pin_s2  <= next_pin_s2;
            en_last <= next_en_last;
        end
    end

    // a low pin at reset release is no shutdown, only a falling edge counts
    assign en_fall   = en_last & ~pin_s2[0];
    assign sleep_low = ~pin_s2[1];

    logic [PMR_FLAG_W-1:0] flags, next_flags, set_vec;
    logic                  irq_sd, next_irq_sd, mask_sd, next_mask_sd, next_pending;
    logic [7:0]            rail1, next_rail1, rail2, next_rail2, rail3, next_rail3;
    logic [2:0]            next_pg, code_zero;
    logic                  wr_flags, wr_irq, wr_mask, fault_trip;

    // register writes and hardware sets; a set always beats a same-cycle clear
    always_comb begin
        wr_flags   = bus.wr && (bus.addr == PMR_OFS_FLAGS);
        wr_irq     = bus.wr && (bus.addr == PMR_OFS_IRQ);
        wr_mask    = bus.wr && (bus.addr == PMR_OFS_MASK);
        fault_trip = undervoltage_trip | power_fault_trip | critical_temp_trip;
        set_vec    = {en_fall, undervoltage_trip, power_fault_trip, critical_temp_trip};
        next_flags = flags;
        if (wr_flags) begin
            next_flags = flags & ~bus.wdata[PMR_FLAG_W-1:0];
        end
        next_flags  = next_flags | set_vec;
        next_irq_sd = irq_sd;
        if (wr_irq && bus.wdata[PMR_BIT_SDEV]) begin
            next_irq_sd = 1'b0;
        end
        if (fault_trip) begin
            next_irq_sd = 1'b1;
        end
        next_mask_sd = wr_mask ? bus.wdata[PMR_BIT_SDEV] : mask_sd;
        next_pending = next_irq_sd & ~next_mask_sd;
        next_rail1   = (bus.wr && bus.addr == PMR_OFS_RAIL1) ? bus.wdata : rail1;
        next_rail2   = (bus.wr && bus.addr == PMR_OFS_RAIL2) ? bus.wdata : rail2;
        next_rail3   = (bus.wr && bus.addr == PMR_OFS_RAIL3) ? bus.wdata : rail3;
        code_zero    = {next_rail3[PMR_VID_W-1:0] == '0, next_rail2[PMR_VID_W-1:0] == '0,
                        next_rail1[PMR_VID_W-1:0] == '0};
        // power good is forced high at code zero or during sleep
        next_pg      = rail_pg_raw | code_zero | {3{sleep_low}};
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            flags                <= PMR_RST_FLAGS;
            irq_sd               <= PMR_RST_IRQ;
            mask_sd              <= PMR_RST_MASK;
            rail1                <= PMR_RST_RAIL1;
            rail2                <= PMR_RST_RAIL2;
            rail3                <= PMR_RST_RAIL3;
            power_good           <= 3'h7;
            shutdown_irq_pending <= 1'b0;
        end else begin
            flags                <= next_flags;
            irq_sd               <= next_irq_sd;
            mask_sd              <= next_mask_sd;
            rail1                <= next_rail1;
            rail2                <= next_rail2;
            rail3                <= next_rail3;
            power_good           <= next_pg;
            shutdown_irq_pending <= next_pending;
        end
    end

    // read-back; no read has a side effect, unmapped offsets read zero
    always_comb begin
        case (bus.addr)
            PMR_OFS_IRQ:   bus.rdata = PMR_RSVD_IRQ | (8'(irq_sd) << PMR_BIT_SDEV);
            PMR_OFS_MASK:  bus.rdata = PMR_RSVD_MASK | (8'(mask_sd) << PMR_BIT_SDEV);
            PMR_OFS_FLAGS: bus.rdata = {4'h0, flags};
            PMR_OFS_RAIL1: bus.rdata = rail1;
            PMR_OFS_RAIL2: bus.rdata = rail2;
            PMR_OFS_RAIL3: bus.rdata = rail3;
            default:       bus.rdata = PMR_RD_UNMAP;
        endcase
    end

    assign rail1_voltage_field = rail1[PMR_VID_W-1:0];
    assign rail2_voltage_field = rail2[PMR_VID_W-1:0];
    assign rail3_voltage_field = rail3[PMR_VID_W-1:0];

    sequence uv_clear_s;
        bus.wr && bus.addr == PMR_OFS_FLAGS && bus.wdata[PMR_BIT_UV] && !undervoltage_trip;
    endsequence

    sequence ct_keep_s;
        bus.wr && bus.addr == PMR_OFS_FLAGS && !bus.wdata[PMR_BIT_CT] && flags[PMR_BIT_CT];
    endsequence

    // a lockout trip raises its flag and the interrupt bit on the same edge
    sequence uv_raise_s;
        flags[PMR_BIT_UV] && irq_sd;
    endsequence

    flag_clear_a: assert property (@(posedge clk) disable iff (rst)
        uv_clear_s |=> !flags[PMR_BIT_UV])
        else $error("undervoltage flag not cleared");
    enpin_flag_a: assert property (@(posedge clk) disable iff (rst)
        $fell(pin_s2[0]) |-> ##1 flags[PMR_BIT_ENPIN])
        else $error("enable pin flag missed");
    uv_flag_a: assert property (@(posedge clk) disable iff (rst)
        undervoltage_trip |=> uv_raise_s)
        else $error("uv flag missed");
    // a clear written in the cycle after the trip may take the flag down again
    pf_flag_a: assert property (@(posedge clk) disable iff (rst)
        power_fault_trip |=> flags[PMR_BIT_PF] ##1 (flags[PMR_BIT_PF] || $past(wr_flags)))
        else $error("pf flag");
    ct_flag_a: assert property (@(posedge clk) disable iff (rst)
        critical_temp_trip |=> flags[PMR_BIT_CT])
        else $error("crit temp flag missed");
    irq_link_a: assert property (@(posedge clk) disable iff (rst)
        $rose(flags[2:0] != 3'h0) |-> irq_sd)
        else $error("shutdown irq not set");
    // only the first edge after release: before it rst disables the check, after it a write may move the codes
    rail_reset_a: assert property (@(posedge clk) disable iff (rst)
        $past(rst) |-> rail1_voltage_field == 7'h38 && rail3_voltage_field == 7'h11
        && rail2_voltage_field == 7'h00) else $error("rail reset value wrong");
    rail2_write_a: assert property (@(posedge clk) disable iff (rst)
        bus.wr && bus.addr == 8'h21 |=> rail2 == $past(bus.wdata))
        else $error("rail2 write lost");
    // a write in the same cycle may move the code away from zero
    pg_forced_a: assert property (@(posedge clk) disable iff (rst)
        (sleep_low || rail1[6:0] == 7'h00) && !bus.wr |=> power_good[0])
        else $error("power good dropped");
    irq_clear_a: assert property (@(posedge clk) disable iff (rst)
        wr_irq && bus.wdata[3] && !fault_trip |=> !irq_sd)
        else $error("irq not cleared");
    mask_gate_a: assert property (@(posedge clk) disable iff (rst)
        ##1 shutdown_irq_pending == (irq_sd && !mask_sd))
        else $error("mask gating wrong");
    ct_keep_a: assert property (@(posedge clk) disable iff (rst)
        ct_keep_s |=> flags[PMR_BIT_CT])
        else $error("flag lost on zero write");

    // write paths of the other two rails and the sticky hold of flag and interrupt
    rail1_write_a: assert property (@(posedge clk) disable iff (rst)
        bus.wr && bus.addr == PMR_OFS_RAIL1 |=> rail1_voltage_field == $past(bus.wdata[PMR_VID_W-1:0]))
        else $error("rail1 write lost");
    rail3_write_a: assert property (@(posedge clk) disable iff (rst)
        bus.wr && bus.addr == PMR_OFS_RAIL3 |=> rail3_voltage_field == $past(bus.wdata[PMR_VID_W-1:0]))
        else $error("rail3 write lost");
    flag_rsvd_a: assert property (@(posedge clk) disable iff (rst)
        bus.addr == PMR_OFS_FLAGS |-> bus.rdata[7:4] == 4'h0)
        else $error("flag register upper bits not zero");
    mask_reset_a: assert property (@(posedge clk) disable iff (rst)
        $past(rst) |-> mask_sd && !irq_sd && flags == '0 && !shutdown_irq_pending)
        else $error("interrupt reset state wrong");
    pg_sleep_a: assert property (@(posedge clk) disable iff (rst)
        sleep_low |=> power_good == 3'h7)
        else $error("power good low during sleep");
    pg_zero3_a: assert property (@(posedge clk) disable iff (rst)
        rail3[6:0] == 7'h00 && !bus.wr |=> power_good[2])
        else $error("rail3 power good dropped at code zero");
    irq_hold_a: assert property (@(posedge clk) disable iff (rst)
        irq_sd && !wr_irq |=> irq_sd)
        else $error("shutdown irq lost without clear");
    flag_hold_a: assert property (@(posedge clk) disable iff (rst)
        flags[PMR_BIT_ENPIN] && !wr_flags |=> flags[PMR_BIT_ENPIN])
        else $error("enable pin flag lost without clear");
endmodule : pmr_shutdown_rail_regs
`default_nettype wire

// ### tb/pmr_host_model.sv
// two-wire bus controller model standing in for the host
`default_nettype none
module pmr_host_model (
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_oe,
    output int        nacks
);
    timeunit 1ns;
    timeprecision 1ps;
    import pmr_pkg::*;

    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
        nacks = 0;
    end

    // wait n edges, then step just past the edge
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : hold

    // one clock pulse; 6 clocks of setup because the target samples through synchronisers
    task automatic pulse(output logic b);
        hold(6);
        scl = 1'b1;
        hold(4);
        b = sda;
        hold(4);
        scl = 1'b0;
        hold(2);
    endtask : pulse

    // start, also used as repeated start; waits for the target to let go of an ack
    task automatic start_cond;
        sda_oe = 1'b0;
        hold(6);
        scl = 1'b1;
        hold(8);
        sda_oe = 1'b1;
        hold(8);
        scl = 1'b0;
        hold(2);
    endtask : start_cond

    task automatic stop_cond;
        sda_oe = 1'b1;
        hold(6);
        scl = 1'b1;
        hold(8);
        sda_oe = 1'b0;
        hold(8);
    endtask : stop_cond

    // msb first, then the target must pull the ninth bit low
    task automatic send(input logic [7:0] d);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            sda_oe = ~d[i];
            pulse(b);
        end
        sda_oe = 1'b0;
        pulse(b);
        if (b !== 1'b0) nacks++;
    endtask : send

    // released line floats high through the pull-up while the target drives
    task automatic recv(input logic last, output logic [7:0] d);
        logic b;
        sda_oe = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            pulse(b);
            d[i] = b;
        end
        sda_oe = ~last;
        pulse(b);
    endtask : recv

    task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
        start_cond();
        send({PMR_I2C_ADDR, 1'b0});
        send(ptr);
        send(d);
        stop_cond();
    endtask : wr

    task automatic rd(input logic [7:0] ptr, output logic [7:0] d);
        start_cond();
        send({PMR_I2C_ADDR, 1'b0});
        send(ptr);
        start_cond();
        send({PMR_I2C_ADDR, 1'b1});
        recv(1'b1, d);
        stop_cond();
    endtask : rd
endmodule : pmr_host_model
`default_nettype wire

// ### tb/tb_shutdown_source_and_rail_voltage_regs.sv
// self-checking bench: serial accesses, shutdown events and rail codes against a model
`default_nettype none
module tb_shutdown_source_and_rail_voltage_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import pmr_pkg::*;

    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       en_pin = 1'b0;
    logic       sleep = 1'b0;
    logic       uv = 1'b0;
    logic       pf = 1'b0;
    logic       ct = 1'b0;
    logic [2:0] pg_raw = 3'h0;
    logic [6:0] v1, v2, v3;
    logic [2:0] pg;
    logic       pend, dut_oe, host_oe, scl;
    wire  logic sda = ~(dut_oe | host_oe);
    int         nacks;
    int         mismatches = 0;
    int         comparisons = 0;
    logic [7:0] exp_reg [256];
    logic [7:0] d;

    always #20 clk = ~clk;

    pmr_shutdown_rail_regs uut (
        .clk(clk), .rst(rst), .scl_pin(scl), .sda_in(sda), .sda_out(), .sda_oe(dut_oe),
        .device_enable_pin(en_pin), .sleep_s0_signal(sleep), .undervoltage_trip(uv),
        .power_fault_trip(pf), .critical_temp_trip(ct), .rail_pg_raw(pg_raw),
        .rail1_voltage_field(v1), .rail2_voltage_field(v2), .rail3_voltage_field(v3),
        .power_good(pg), .shutdown_irq_pending(pend)
    );

    pmr_host_model host (.clk(clk), .sda(sda), .scl(scl), .sda_oe(host_oe), .nacks(nacks));

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        comparisons++;
        if (seen !== want) begin
            mismatches++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    // write through the serial port and update the model the same way
    task automatic hw(input logic [7:0] ptr, input logic [7:0] v);
        host.wr(ptr, v);
        case (ptr)
            8'h02: if (v[3]) exp_reg[ptr][3] = 1'b0;
            8'h03: exp_reg[ptr] = 8'hf7 | (v & 8'h08);
            8'h05: exp_reg[ptr] = exp_reg[ptr] & ~{4'h0, v[3:0]};
            8'h20, 8'h21, 8'h23: exp_reg[ptr] = v;
            default: ;
        endcase
    endtask : hw

    task automatic hr(input logic [7:0] ptr);
        logic [7:0] got;
        host.rd(ptr, got);
        check(got, exp_reg[ptr]);
    endtask : hr

    // pins that follow the registers, sleep and raw power goods
    task automatic outs;
        logic [2:0] want;
        want = pg_raw | {3{~sleep}};
        want = want | {exp_reg[8'h23][6:0] == 0, exp_reg[8'h21][6:0] == 0, exp_reg[8'h20][6:0] == 0};
        check({1'b0, v1}, {1'b0, exp_reg[8'h20][6:0]});
        check({1'b0, v2}, {1'b0, exp_reg[8'h21][6:0]});
        check({1'b0, v3}, {1'b0, exp_reg[8'h23][6:0]});
        check({5'h0, pg}, {5'h0, want});
        check({7'h0, pend}, {7'h0, exp_reg[2][3] & ~exp_reg[3][3]});
    endtask : outs

    // one-cycle trip pulse; bit 2 undervoltage, 1 power fault, 0 critical temperature
    task automatic trip(input int b);
        {uv, pf, ct} = 3'b001 << b;
        tick(1);
        {uv, pf, ct} = 3'b000;
        exp_reg[5][b] = 1'b1;
        exp_reg[2][3] = 1'b1;
        tick(2);
        outs();
    endtask : trip

    // cut a hang short after well over the expected run length
    initial begin
        #3600000;
        mismatches++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(32'hcbe9));
        foreach (exp_reg[i]) exp_reg[i] = 8'h00;
        exp_reg[8'h03] = 8'hff;
        exp_reg[8'h20] = 8'h38;
        exp_reg[8'h23] = 8'h11;
        tick(4);
        rst = 1'b0;
        tick(1);
        outs();
        tick(4);
        // reset values, an unmapped offset among them
        hr(8'h02);
        hr(8'h03);
        hr(8'h05);
        hr(8'h20);
        hr(8'h21);
        hr(8'h22);
        hr(8'h23);
        sleep = 1'b1;
        tick(6);
        outs();
        // random codes; rail 2 then set to zero while its raw power good is low
        for (int i = 0; i < 3; i++) begin
            d = 8'($urandom());
            hw(i == 2 ? 8'h23 : 8'h20 + 8'(i), d);
            hr(i == 2 ? 8'h23 : 8'h20 + 8'(i));
        end
        hw(8'h21, 8'h00);
        hr(8'h21);
        tick(2);
        outs();
        sleep = 1'b0;
        pg_raw = 3'b010;
        tick(6);
        outs();
        for (int b = 0; b < 3; b++) begin
            trip(b);
            hr(8'h05);
            hr(8'h02);
        end
        hw(8'h03, 8'h00);
        hr(8'h03);
        outs();
        hw(8'h05, 8'hf0);
        hr(8'h05);
        hw(8'h05, 8'h02);
        hr(8'h05);
        hw(8'h02, 8'h08);
        hr(8'h02);
        outs();
        // enable pin high then low: a shutdown by the host
        en_pin = 1'b1;
        tick(8);
        en_pin = 1'b0;
        tick(8);
        exp_reg[5][3] = 1'b1;
        hr(8'h05);
        hr(8'h02);
        trip(2);
        hw(8'h05, 8'h0f);
        hr(8'h05);
        check(nacks[7:0], 8'h00);
        // a frame to another target address gets no acknowledge and changes nothing
        host.start_cond();
        host.send({PMR_I2C_ADDR ^ 7'h01, 1'b0});
        host.stop_cond();
        check(nacks[7:0], 8'h01);
        hr(8'h05);
        tally_and_finish();
    end
endmodule : tb_shutdown_source_and_rail_voltage_regs
`default_nettype wire
